// *** epv_arbiter.sv ***
/*
 Pending-exception arbiter: picks the smallest key, lowest vector on a tie.
 Assumes keys already hold group rank above subpriority.
*/
`timescale 1ns/1ps
module epv_arbiter import epv_pkg::*; (
    input  wire logic [NUM_VEC-1:0]            pend,
    input  wire logic [NUM_VEC-1:0][KEY_W-1:0] keys,
    output logic                               win_valid,
    output logic [VEC_W-1:0]                   win_vec,
    output logic [KEY_W-1:0]                   win_key
);
    // Ascending scan with strict compare keeps the lower vector on ties
    always_comb begin
        win_valid = 1'b0;
        win_vec   = '0;
        win_key   = '1;
        for (int i = 0; i < NUM_VEC; i++) begin
            if (pend[i] && (!win_valid || keys[i] < win_key)) begin // [RULE8] [RULE11] [RULE15]
                win_valid = 1'b1;
                win_vec   = VEC_W'(i);
                win_key   = keys[i];
            end
        end
    end
endmodule

// *** epv_core_model.sv ***
/*
 Behavioural processor core: takes the offered vector by pulsing an acknowledge.
 Assumes exc_req and exc_vec are registered outputs of the unit.
*/
`timescale 1ns/1ps
module epv_core_model import epv_pkg::*; (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             take_en,
    input  wire logic [3:0]       lag,
    input  wire logic             exc_req,
    input  wire logic [VEC_W-1:0] exc_vec,
    output logic                  cpu_ack = 1'b0,
    output logic [VEC_W-1:0]      ack_vec = 6'h00
);
    int wait_n = 0;
    // Never acks two cycles running: a high cpu_ack forces the next cycle idle, as exc_req is still high then
    always @(posedge clock) begin
        if (rst || cpu_ack || !take_en || !exc_req) begin
            cpu_ack <= 1'b0;
            ack_vec <= ~ack_vec;
            wait_n  <= 0;
        end else if (wait_n < lag) begin
            wait_n <= wait_n + 1;
        end else begin
            cpu_ack <= 1'b1;
            ack_vec <= exc_vec;
        end
    end
endmodule

// *** epv_pkg.sv ***
/*
 Constants and state type for the exception priority and vector unit.
 Assumes one system clock, a synchronous active-high reset, and a core
 that reports its running handler and acknowledges taken exceptions.
*/
package epv_pkg;
    localparam int NUM_IRQ = 44;
    localparam int NUM_VEC = 64;
    localparam int NUM_SYS = 16;
    localparam int VEC_W   = 6;
    localparam int PRIO_W  = 3;
    localparam int RANK_W  = 4;
    localparam int KEY_W   = RANK_W + PRIO_W;

    localparam logic [VEC_W-1:0]  VEC_RESET   = 6'h01;
    localparam logic [VEC_W-1:0]  VEC_NMI     = 6'h02;
    localparam logic [VEC_W-1:0]  VEC_HF      = 6'h03;
    localparam logic [VEC_W-1:0]  IRQ_VEC_OFS = 6'h10;
    localparam logic [31:0]       IRQ_TABLE_OFS = 32'h0000_0040;

    // Interrupt lines 9-13, 32-34 and 37-41 have no source
    localparam logic [NUM_IRQ-1:0] IRQ_VALID_MASK = 44'hc18_ffff_c1ff;
    // Vectors 2-6, 11, 12, 14 and 15 are real core exceptions
    localparam logic [NUM_SYS-1:0] SYS_VALID_MASK = 16'hd87c;

    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] BASE_MIN   = 32'h0000_0100;
    localparam logic [31:0] BASE_MAX   = 32'h3fff_ff00;
    localparam logic [31:0] BASE_ALIGN = 32'hffff_ff00;

    localparam logic [PRIO_W-1:0] PRIO_RESET  = 3'h0;
    localparam logic [2:0]        GRP_RESET   = 3'h0;
    localparam logic [2:0]        GRP_SUB_OFS = 3'h4;
    localparam logic [RANK_W-1:0] RANK_RESET  = 4'h0;
    localparam logic [RANK_W-1:0] RANK_NMI    = 4'h1;
    localparam logic [RANK_W-1:0] RANK_HF     = 4'h2;
    localparam logic [RANK_W-1:0] RANK_CFG    = 4'h3;

    typedef struct packed {
        logic [31:0]                     base;
        logic [2:0]                      grp;
        logic [NUM_VEC-1:0][PRIO_W-1:0]  prio;
        logic [NUM_VEC-1:0]              pend;
        logic                            req;
        logic [VEC_W-1:0]                vec;
        logic [31:0]                     addr;
        logic [KEY_W-1:0]                key;
    } epv_state_t;
endpackage

// *** epv_unit.sv ***
/*
 Exception priority and vector unit: pending state, priorities, grouping,
 relocatable table base, arbitration and preemption decision.
 Assumes a core that reports its most urgent active handler, pulses an
 acknowledge for the vector it takes, and fetches from exc_addr.
*/
`timescale 1ns/1ps
// What this block and its software must do
// [RULE1] Line k maps to vector k+16
// [RULE2] Reserved interrupt lines never become pending
// [RULE3] Table holds stack top then handlers
// [RULE4] Software sets handler address bit zero
// [RULE5] Table base is zero after reset
// [RULE6] Privileged writes relocate base within range
// [RULE7] Software aligns base to 256 bytes
// [RULE8] Smaller priority value is more urgent
// [RULE9] All configurable priorities reset to zero
// [RULE10] Configurable priorities span zero to seven
// [RULE11] Equal priority: lowest exception number wins
// [RULE12] Only strictly more urgent exceptions preempt
// [RULE13] Grouping control splits group and subpriority
// [RULE14] Preemption compares group priority only
// [RULE15] Subpriority then number orders equal groups
// [RULE16] Non-maskable interrupt fixed at level minus two
// [RULE17] Hard fault fixed at level minus one
// [RULE18] Fetch address is base plus four times vector
module epv_unit import epv_pkg::*; (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic [NUM_IRQ-1:0]  irq_lines,
    input  wire logic [NUM_SYS-1:0]  sys_req,
    input  wire logic                base_wr,
    input  wire logic                base_priv,
    input  wire logic [31:0]         base_data,
    input  wire logic                grp_wr,
    input  wire logic [2:0]          grp_data,
    input  wire logic                prio_wr,
    input  wire logic [VEC_W-1:0]    prio_vec,
    input  wire logic [PRIO_W-1:0]   prio_data,
    input  wire logic                act_valid,
    input  wire logic [VEC_W-1:0]    act_vec,
    input  wire logic                cpu_ack,
    input  wire logic [VEC_W-1:0]    ack_vec,
    output logic                     exc_req,
    output logic [VEC_W-1:0]         exc_vec,
    output logic [31:0]              exc_addr,
    output logic [KEY_W-1:0]         exc_key,
    output logic [31:0]              vector_base_offset_reg,
    output logic [31:0]              sp_addr,
    output logic [NUM_VEC-1:0]       pend_vec
);
    epv_state_t s_q;
    epv_state_t s_d;

    logic [NUM_VEC-1:0]            keys_pend;
    logic [NUM_VEC-1:0][KEY_W-1:0] keys;
    logic [NUM_VEC-1:0]            set_raw;
    logic                          win_valid;
    logic [VEC_W-1:0]              win_vec;
    logic [KEY_W-1:0]              win_key;
    logic [KEY_W-1:0]              act_key;
    logic                          preempt;

    function automatic logic [PRIO_W-1:0] group_mask(input logic [2:0] grp);
        logic [2:0] sub_bits;
        sub_bits = (grp > GRP_SUB_OFS) ? grp - GRP_SUB_OFS : 3'h0;
        return PRIO_W'(3'h7 << sub_bits);
    endfunction

    // Fixed levels sit below the smallest configurable rank
    function automatic logic [KEY_W-1:0] key_of(input logic [VEC_W-1:0] vec,
                                               input logic [PRIO_W-1:0] prio,
                                               input logic [2:0] grp);
        logic [PRIO_W-1:0] gm;
        gm = group_mask(grp);
        if (vec == VEC_NMI) begin
            return {RANK_NMI, 3'h0}; // [RULE16]
        end else if (vec == VEC_HF) begin
            return {RANK_HF, 3'h0}; // [RULE17]
        end else if (vec == VEC_RESET) begin
            return {RANK_RESET, 3'h0};
        end else begin
            return {RANK_W'({1'b0, prio & gm}) + RANK_CFG, prio & ~gm}; // [RULE10] [RULE13]
        end
    endfunction

    function automatic logic configurable(input logic [VEC_W-1:0] vec);
        logic [NUM_VEC-1:0] ok;
        ok = {{(NUM_VEC-NUM_SYS-NUM_IRQ){1'b0}}, IRQ_VALID_MASK, SYS_VALID_MASK};
        return ok[vec] && vec != VEC_NMI && vec != VEC_HF; // [RULE8]
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_VEC; g++) begin : g_key
            assign keys[g] = key_of(VEC_W'(g), s_q.prio[g], s_q.grp);
        end
    endgenerate

    // Reserved lines are masked before they can reach pending
    assign set_raw = {{(NUM_VEC-NUM_SYS-NUM_IRQ){1'b0}},
                      irq_lines & IRQ_VALID_MASK, // [RULE1] [RULE2]
                      sys_req & SYS_VALID_MASK};
    assign keys_pend = s_q.pend;
    assign act_key   = keys[act_vec];

    epv_arbiter u_arb (
        .pend      (keys_pend),
        .keys      (keys),
        .win_valid (win_valid),
        .win_vec   (win_vec),
        .win_key   (win_key)
    );

    // Equal group never preempts, whatever the subpriority or number
    assign preempt = win_valid && (!act_valid || win_key[KEY_W-1:PRIO_W] < act_key[KEY_W-1:PRIO_W]); // [RULE12] [RULE14]

    always_comb begin
        s_d = s_q;
        if (grp_wr) begin
            s_d.grp = grp_data; // [RULE13]
        end
        // Out-of-range or unprivileged writes are dropped, the old base stays
        if (base_wr && base_priv && base_data >= BASE_MIN && base_data <= BASE_MAX) begin
            s_d.base = base_data & BASE_ALIGN; // [RULE6] [RULE7]
        end
        if (prio_wr && configurable(prio_vec)) begin
            s_d.prio[prio_vec] = prio_data; // [RULE10]
        end
        if (cpu_ack) begin
            s_d.pend[ack_vec] = 1'b0;
        end
        // Set after clear so an arrival in the ack cycle is kept
        s_d.pend = s_d.pend | set_raw; // [RULE12]
        s_d.req  = preempt && !cpu_ack;
        s_d.vec  = win_vec;
        s_d.key  = win_key;
        s_d.addr = s_q.base + {24'h0, win_vec, 2'b00}; // [RULE1] [RULE3] [RULE18]
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_q      <= '0;
            s_q.base <= BASE_RESET; // [RULE5]
            s_q.grp  <= GRP_RESET;
            s_q.prio <= {NUM_VEC{PRIO_RESET}}; // [RULE9]
        end else begin
            s_q <= s_d;
        end
    end

    assign exc_req                = s_q.req;
    assign exc_vec                = s_q.vec;
    assign exc_addr               = s_q.addr;
    assign exc_key                = s_q.key;
    assign vector_base_offset_reg = s_q.base;
    assign sp_addr                = s_q.base; // [RULE3]
    assign pend_vec               = s_q.pend;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_reserved_never_pending;
        (s_q.pend & ~{{(NUM_VEC-NUM_SYS-NUM_IRQ){1'b0}}, IRQ_VALID_MASK, SYS_VALID_MASK}) == '0;
    endproperty
    a_reserved_never_pending: assert property (p_reserved_never_pending) else $error("reserved vector pending"); // [RULE2]

    property p_line_maps;
        irq_lines[0] |=> s_q.pend[IRQ_VEC_OFS];
    endproperty
    a_line_maps: assert property (p_line_maps) else $error("line 0 did not pend vector 16"); // [RULE1]

    property p_irq_addr;
        (win_vec == IRQ_VEC_OFS && !base_wr) |=> exc_addr == vector_base_offset_reg + IRQ_TABLE_OFS;
    endproperty
    a_irq_addr: assert property (p_irq_addr) else $error("first peripheral vector address wrong"); // [RULE1]

    property p_reset_state;
        disable iff (1'b0) rst |=> vector_base_offset_reg == BASE_RESET && s_q.prio == '0 && !exc_req;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong"); // [RULE5] [RULE9]

    property p_base_range;
        vector_base_offset_reg == BASE_RESET ||
        (vector_base_offset_reg >= BASE_MIN && vector_base_offset_reg <= BASE_MAX &&
         vector_base_offset_reg[7:0] == 8'h00);
    endproperty
    a_base_range: assert property (p_base_range) else $error("table base out of range"); // [RULE6]

    property p_fetch_addr;
        1'b1 |=> exc_addr == $past(s_q.base) + {24'h0, $past(win_vec), 2'b00};
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address not base plus 4*vector"); // [RULE18]

    property p_smaller_wins;
        (s_q.pend[16] && s_q.pend[17] && s_q.grp == 3'h0 && s_q.prio[17] < s_q.prio[16] &&
         (s_q.pend & ~64'h0000_0000_0003_0000) == '0) |-> win_vec == 6'h11;
    endproperty
    a_smaller_wins: assert property (p_smaller_wins) else $error("less urgent priority won"); // [RULE8]

    property p_tie_low_number;
        (s_q.pend[16] && s_q.pend[17] && keys[16] == keys[17] && keys[16] <= win_key) |-> win_vec != 6'h11;
    endproperty
    a_tie_low_number: assert property (p_tie_low_number) else $error("tie not given to lower number"); // [RULE11] [RULE15]

    property p_no_equal_preempt;
        (act_valid && win_valid && win_key[KEY_W-1:PRIO_W] >= act_key[KEY_W-1:PRIO_W]) |=> !exc_req;
    endproperty
    a_no_equal_preempt: assert property (p_no_equal_preempt) else $error("preempted without more urgent group"); // [RULE12] [RULE14]

    property p_nmi_taken;
        (sys_req[2] && !(act_valid && act_vec == VEC_NMI)) ##1 (!cpu_ack && !(act_valid && act_vec == VEC_NMI))
            |=> exc_req && exc_vec == VEC_NMI;
    endproperty
    a_nmi_taken: assert property (p_nmi_taken) else $error("NMI not requested within two cycles"); // [RULE16]

    property p_hf_over_cfg;
        (s_q.pend[VEC_HF] && !s_q.pend[VEC_NMI] && !s_q.pend[VEC_RESET]) |-> win_vec == VEC_HF;
    endproperty
    a_hf_over_cfg: assert property (p_hf_over_cfg) else $error("hard fault lost to configurable"); // [RULE17]

    property p_cfg_rank;
        keys[16][KEY_W-1:PRIO_W] >= RANK_CFG && keys[16][PRIO_W-1:0] == (s_q.prio[16] & ~group_mask(s_q.grp));
    endproperty
    a_cfg_rank: assert property (p_cfg_rank) else $error("configurable key split wrong"); // [RULE10] [RULE13]

    c_nmi:      cover property (exc_req && exc_vec == VEC_NMI);
    c_preempt:  cover property (act_valid && exc_req);
    c_tie:      cover property (s_q.pend[16] && s_q.pend[17] && keys[16] == keys[17]);
    c_relocate: cover property (vector_base_offset_reg != BASE_RESET);
endmodule

// *** epv_unit_tb.sv ***
/*
 Self-checking bench for the exception priority and vector unit.
 Assumes the core model acks offered vectors; compares with a queue-free integer model.
*/
`timescale 1ns/1ps
module epv_unit_tb import epv_pkg::*;;
    logic               clock = 1'b0, rst = 1'b1, base_wr = 1'b0, base_priv = 1'b0;
    logic               grp_wr = 1'b0, prio_wr = 1'b0, act_valid = 1'b0, take_en = 1'b0;
    logic [NUM_IRQ-1:0] irq_lines = '0;
    logic [NUM_SYS-1:0] sys_req = '0;
    logic [31:0]        base_data = '0, m_base = '0;
    logic [2:0]         grp_data = '0;
    logic [VEC_W-1:0]   prio_vec = '0, act_vec = '0, exc_vec, ack_vec;
    logic [PRIO_W-1:0]  prio_data = '0;
    logic [3:0]         lag = '0;
    logic               exc_req, cpu_ack;
    logic [31:0]        exc_addr, vbase, sp_addr;
    logic [KEY_W-1:0]   exc_key;
    logic [NUM_VEC-1:0] pend_vec, m_pend = '0;
    int                 num_errors = 0, check_count = 0, m_grp = 0, m_prio [NUM_VEC];
    // Unprivileged, below range, above range, zero after relocation are refused
    logic [32:0]        tbl [7] = '{33'h1_0000_0200, 33'h0_0000_0400, 33'h1_0000_00ff,
                                    33'h1_4000_0000, 33'h1_3fff_ff00, 33'h1_0000_0100, 33'h1_0000_0000};

    epv_unit uut (.clock(clock), .rst(rst), .irq_lines(irq_lines), .sys_req(sys_req),
        .base_wr(base_wr), .base_priv(base_priv), .base_data(base_data), .grp_wr(grp_wr),
        .grp_data(grp_data), .prio_wr(prio_wr), .prio_vec(prio_vec), .prio_data(prio_data),
        .act_valid(act_valid), .act_vec(act_vec), .cpu_ack(cpu_ack), .ack_vec(ack_vec),
        .exc_req(exc_req), .exc_vec(exc_vec), .exc_addr(exc_addr), .exc_key(exc_key),
        .vector_base_offset_reg(vbase), .sp_addr(sp_addr), .pend_vec(pend_vec));
    epv_core_model core (.clock(clock), .rst(rst), .take_en(take_en), .lag(lag),
        .exc_req(exc_req), .exc_vec(exc_vec), .cpu_ack(cpu_ack), .ack_vec(ack_vec));

    always #10 clock = ~clock;

    function automatic int key_of(int v);
        int s;
        s = (m_grp > 4) ? m_grp - 4 : 0;
        if (v == 2)
            return 8;
        if (v == 3)
            return 16;
        // Group field stays in place, unshifted, offset by the configurable rank base
        return ((((m_prio[v] & ~((1 << s) - 1)) + 3) << 3) | (m_prio[v] & ((1 << s) - 1)));
    endfunction

    function automatic int pick_vec();
        int v;
        do v = 2 + $urandom_range(57);
        while (!(v < 16 ? SYS_VALID_MASK[v] : IRQ_VALID_MASK[v-16]));
        return v;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic compare_all();
        int   w;
        logic req;
        w = -1;
        for (int v = 0; v < NUM_VEC; v++)
            if (m_pend[v] && (w < 0 || key_of(v) < key_of(w)))
                w = v;
        req = (w >= 0) && (!act_valid || (key_of(w) >> 3) < (key_of(act_vec) >> 3));
        chk(pend_vec, m_pend, "pending");
        chk(exc_req, req, "request");
        if (req) begin
            chk(exc_vec, w, "vector");
            chk(exc_key, key_of(w), "key");
            chk(exc_addr, m_base + 4 * w, "address");
            // Fetch is word aligned; bit 0 of the entry itself is software's to set
            chk(exc_addr[1:0], 0, "word fetch");
        end
        chk(vbase, m_base, "base");
        chk(sp_addr, m_base, "stack top");
    endtask

    task automatic reset_all();
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        m_base = '0;
        m_grp = 0;
        m_pend = '0;
        foreach (m_prio[v]) m_prio[v] = 0;
        @(negedge clock);
        compare_all();
    endtask

    // A negative index skips configuration, so reset priorities are exercised
    task automatic stim(input int i);
        logic [32:0]        d;
        logic [NUM_VEC-1:0] hit;
        int                 v, p;
        d = (i >= 0 && i < 7) ? tbl[i] : {1'b1, 2'b00, 22'($urandom), 8'h00};
        for (int n = 0; n < 6 && i >= 0; n++) begin
            v = $urandom_range(63);
            p = $urandom_range(7);
            @(posedge clock);
            base_wr <= (n == 0);
            base_priv <= d[32];
            base_data <= d[31:0];
            grp_wr <= (n == 0);
            grp_data <= 3'(p);
            prio_wr <= 1'b1;
            prio_vec <= 6'(v);
            prio_data <= 3'(p);
            if (n == 0)
                m_grp = p;
            if (n == 0 && d[32] && d[31:0] >= 32'h0000_0100 && d[31:0] <= 32'h3fff_ff00)
                m_base = d[31:0] & 32'hffff_ff00;
            if (v >= 4 && v < 60 && (v < 16 ? SYS_VALID_MASK[v] : IRQ_VALID_MASK[v-16]))
                m_prio[v] = p;
        end
        hit = '0;
        repeat ($urandom_range(4, 1)) hit[pick_vec()] = 1'b1;
        @(posedge clock);
        prio_wr <= 1'b0;
        irq_lines <= hit[59:16];
        sys_req <= hit[15:0];
        act_valid <= 1'($urandom);
        act_vec <= 6'(pick_vec());
        m_pend |= hit;
        @(posedge clock);
        irq_lines <= '0;
        sys_req <= '0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        compare_all();
        @(posedge clock);
        act_valid <= 1'b0;
        take_en <= 1'b1;
        lag <= 4'($urandom_range(3));
        v = 0;
        do begin
            @(negedge clock);
            v++;
        end while ((pend_vec !== '0 || exc_req !== 1'b0) && v < 300);
        chk(v < 300, 1, "drain");
        m_pend = '0;
        @(posedge clock);
        take_en <= 1'b0;
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Far above the thousand or so cycles the run needs; only a hang reaches it
    initial begin
        #400_000;
        num_errors++;
        complete_run();
    end

    initial begin
        void'($urandom(66212));
        reset_all();
        @(posedge clock);
        irq_lines <= ~IRQ_VALID_MASK;
        sys_req <= ~SYS_VALID_MASK;
        @(posedge clock);
        irq_lines <= '0;
        sys_req <= '0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        compare_all();
        for (int i = 0; i < 40; i++)
            stim(i);
        reset_all();
        stim(-1);
        complete_run();
    end
endmodule
